/* include/adcseq_defs.vh */
// constants for the conversion sequencer: offsets, fields, timing counts
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH
`define ADCSEQ_CLK_HZ            20000000
// register offsets
`define ADCSEQ_OFS_CYCLE_CFG     8'h10
`define ADCSEQ_OFS_TACH_CHSEL    8'h55
`define ADCSEQ_OFS_MODE_CFG      8'h73
`define ADCSEQ_OFS_BYPASS_CFG    8'h7D
// reset values
`define ADCSEQ_RST_CYCLE_CFG     8'h00
`define ADCSEQ_RST_TACH_CHSEL    8'hFF
`define ADCSEQ_RST_MODE_CFG      8'h00
`define ADCSEQ_RST_BYPASS_CFG    8'h00
// field positions
`define ADCSEQ_BIT_LONG_CYCLE    7
`define ADCSEQ_BIT_AVG_OFF       4
`define ADCSEQ_BIT_BYPASS_ALL    5
`define ADCSEQ_BIT_SINGLE        6
`define ADCSEQ_BIT_BYP_2V5       4
`define ADCSEQ_BIT_BYP_CORE      5
`define ADCSEQ_BIT_BYP_5V0       6
`define ADCSEQ_BIT_BYP_12V       7
`define ADCSEQ_CHSEL_MSB         7
`define ADCSEQ_CHSEL_LSB         5
// channel codes
`define ADCSEQ_CH_2V5            3'h0
`define ADCSEQ_CH_CORE           3'h1
`define ADCSEQ_CH_SUPPLY         3'h2
`define ADCSEQ_CH_5V0            3'h3
`define ADCSEQ_CH_12V            3'h4
`define ADCSEQ_CH_REMOTE1        3'h5
`define ADCSEQ_CH_LOCAL          3'h6
`define ADCSEQ_CH_REMOTE2        3'h7
// times in microseconds as printed
`define ADCSEQ_T_VOLT_US         700
`define ADCSEQ_T_REMOTE_US       7000
`define ADCSEQ_T_LOCAL_US        1300
`define ADCSEQ_T_CYCLE_US        146500
`define ADCSEQ_T_LONG_CYCLE_US   240000
// cycle counts derived from the clock rate
`define ADCSEQ_CYC_VOLT    (`ADCSEQ_T_VOLT_US * (`ADCSEQ_CLK_HZ / 1000000))
`define ADCSEQ_CYC_REMOTE  (`ADCSEQ_T_REMOTE_US * (`ADCSEQ_CLK_HZ / 1000000))
`define ADCSEQ_CYC_LOCAL   (`ADCSEQ_T_LOCAL_US * (`ADCSEQ_CLK_HZ / 1000000))
`define ADCSEQ_CYC_CYCLE   (`ADCSEQ_T_CYCLE_US * (`ADCSEQ_CLK_HZ / 1000000))
`define ADCSEQ_CYC_LONG    (`ADCSEQ_T_LONG_CYCLE_US * (`ADCSEQ_CLK_HZ / 1000000))
`define ADCSEQ_AVG_COUNT         16
`define ADCSEQ_CODE_MAX          10'h3FF
`define ADCSEQ_CODE_NOMINAL      10'h300
`endif

/* hw/adcseq_averager.v */
// averager: sums sixteen conversion codes, or passes one through
`timescale 1ns/1ps
`default_nettype none
module adcseq_averager #(
    parameter CODE_W = 10
) (
    input  wire              core_clk,
    input  wire              reset,
    input  wire              start,
    input  wire              sample_valid,
    input  wire [CODE_W-1:0] sample_code,
    input  wire              avg_off,
    output reg               result_valid,
    output reg  [CODE_W-1:0] result_code
);
    reg [CODE_W+3:0] sum_q;
    reg [3:0]        cnt_q;
    wire [CODE_W+3:0] sum_d = sum_q + {4'h0, sample_code};

    // accumulate; the shift by four divides by sixteen without a divider
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sum_q        <= 14'h0000;
            cnt_q        <= 4'h0;
            result_valid <= 1'b0;
            result_code  <= 10'h000;
        end else begin
            result_valid <= 1'b0;
            if (start) begin
                sum_q <= 14'h0000;
                cnt_q <= 4'h0;
            end else if (sample_valid) begin
                if (avg_off) begin
                    result_valid <= 1'b1;
                    result_code  <= sample_code;
                end else if (cnt_q == 4'hF) begin
                    result_valid <= 1'b1;
                    result_code  <= sum_d[CODE_W+3:4];
                    sum_q        <= 14'h0000;
                    cnt_q        <= 4'h0;
                end else begin
                    sum_q <= sum_d;
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* hw/adcseq_top.v */
// conversion sequencer: round robin, single-channel mode, attenuator control
//
// Function
// - averaging off: volt 0.7 ms, remote temp 7 ms, local temp 1.3 ms
// - long-cycle bit set stretches the averaging-off round robin to 240 ms
// - bypass-all bit removes attenuators from all five voltage inputs
// - per-channel bypass bits for 2.5 V, core, 5.0 V and 12 V
// - mode register bits: averaging off, bypass all, single-channel mode
// - single-channel bit stops the round robin on one channel
// - single-channel mode converts the selected input every 0.7 ms
// - single-channel selector is bits 7 to 5 of the tach register
// - selector codes map to the eight channels in fixed order
// - selector shares its byte with the fan tach minimum high byte
// - results are 10-bit codes 0 to 1023, saturating at the top
// - with averaging on, each round-robin result averages sixteen conversions; single-channel results are not averaged
// - with averaging off, the default round robin cycle lasts 146.5 ms
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.vh"
module adcseq_top #(
    parameter CYC_VOLT   = `ADCSEQ_CYC_VOLT,
    parameter CYC_REMOTE = `ADCSEQ_CYC_REMOTE,
    parameter CYC_LOCAL  = `ADCSEQ_CYC_LOCAL,
    parameter CYC_CYCLE  = `ADCSEQ_CYC_CYCLE,
    parameter CYC_LONG   = `ADCSEQ_CYC_LONG
) (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         conv_start,
    output reg  [2:0]  conv_channel,
    output reg         atten_bypass,
    input  wire        conv_done,
    input  wire [11:0] conv_raw,
    output reg         result_valid,
    output reg  [2:0]  result_channel,
    output reg  [9:0]  result_code,
    output reg  [7:0]  tach_min_high
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_GAP  = 2'h2;

    reg [7:0]  cycle_cfg_q;
    reg [7:0]  tach_chsel_q;
    reg [7:0]  mode_cfg_q;
    reg [7:0]  bypass_cfg_q;
    reg [1:0]  state_q;
    reg [2:0]  chan_q;
    reg [22:0] slot_cnt_q;
    reg [22:0] cycle_cnt_q;
    reg        single_q;
    reg [9:0]  sample_q;
    reg        sample_vld_q;
    reg        avg_start_q;
    reg [3:0]  rep_q;
    reg [1:0]  state_d;
    reg        launch;
    reg [2:0]  launch_ch;
    reg [3:0]  launch_rep;
    reg        round_go;

    wire       avg_off    = mode_cfg_q[`ADCSEQ_BIT_AVG_OFF];
    wire       bypass_all = mode_cfg_q[`ADCSEQ_BIT_BYPASS_ALL];
    wire       single_on  = mode_cfg_q[`ADCSEQ_BIT_SINGLE];
    wire       long_cyc   = cycle_cfg_q[`ADCSEQ_BIT_LONG_CYCLE];
    wire [2:0] sel_chan   = tach_chsel_q[`ADCSEQ_CHSEL_MSB:`ADCSEQ_CHSEL_LSB];
    wire       avg_vld;
    wire [9:0] avg_code;

    // slot length for one conversion of a channel with averaging off
    function [22:0] slot_len;
        input [2:0] ch;
        begin
            case (ch)
                `ADCSEQ_CH_REMOTE1: slot_len = CYC_REMOTE[22:0];
                `ADCSEQ_CH_REMOTE2: slot_len = CYC_REMOTE[22:0];
                `ADCSEQ_CH_LOCAL:   slot_len = CYC_LOCAL[22:0];
                default:            slot_len = CYC_VOLT[22:0];
            endcase
        end
    endfunction

    // attenuator bypass per channel; temperature channels have none
    function bypass_for;
        input [2:0] ch;
        input       all;
        input [7:0] cfg;
        begin
            case (ch)
                `ADCSEQ_CH_2V5:    bypass_for = all | cfg[`ADCSEQ_BIT_BYP_2V5];
                `ADCSEQ_CH_CORE:   bypass_for = all | cfg[`ADCSEQ_BIT_BYP_CORE];
                `ADCSEQ_CH_SUPPLY: bypass_for = all;
                `ADCSEQ_CH_5V0:    bypass_for = all | cfg[`ADCSEQ_BIT_BYP_5V0];
                `ADCSEQ_CH_12V:    bypass_for = all | cfg[`ADCSEQ_BIT_BYP_12V];
                default:           bypass_for = 1'b0;
            endcase
        end
    endfunction

    // register writes; the selector byte also drives the tach limit
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cycle_cfg_q  <= `ADCSEQ_RST_CYCLE_CFG;
            tach_chsel_q <= `ADCSEQ_RST_TACH_CHSEL;
            mode_cfg_q   <= `ADCSEQ_RST_MODE_CFG;
            bypass_cfg_q <= `ADCSEQ_RST_BYPASS_CFG;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADCSEQ_OFS_CYCLE_CFG:  cycle_cfg_q  <= reg_wdata;
                `ADCSEQ_OFS_TACH_CHSEL: tach_chsel_q <= reg_wdata;
                `ADCSEQ_OFS_MODE_CFG:   mode_cfg_q   <= reg_wdata;
                `ADCSEQ_OFS_BYPASS_CFG: bypass_cfg_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data registered; unmapped offsets read zero
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata     <= 8'h00;
            tach_min_high <= `ADCSEQ_RST_TACH_CHSEL;
        end else begin
            tach_min_high <= tach_chsel_q;
            if (reg_rd) begin
                case (reg_addr)
                    `ADCSEQ_OFS_CYCLE_CFG:  reg_rdata <= cycle_cfg_q;
                    `ADCSEQ_OFS_TACH_CHSEL: reg_rdata <= tach_chsel_q;
                    `ADCSEQ_OFS_MODE_CFG:   reg_rdata <= mode_cfg_q;
                    `ADCSEQ_OFS_BYPASS_CFG: reg_rdata <= bypass_cfg_q;
                    default:                reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // saturate the raw converter word at full scale
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sample_q     <= 10'h000;
            sample_vld_q <= 1'b0;
        end else begin
            sample_vld_q <= conv_done && (state_q == ST_WAIT);
            if (conv_raw[11:10] != 2'h0)
                sample_q <= `ADCSEQ_CODE_MAX;
            else
                sample_q <= conv_raw[9:0];
        end
    end

    adcseq_averager #(
        .CODE_W       (10)
    ) adcseq_averager_inst (
        .core_clk     (core_clk),
        .reset        (reset),
        .start        (avg_start_q),
        .sample_valid (sample_vld_q),
        .sample_code  (sample_q),
        .avg_off      (avg_off | single_q),
        .result_valid (avg_vld),
        .result_code  (avg_code)
    );

    // next action, decided at the end of each slot or in any gap cycle; a mode change waits for the slot end, except single mode in the gap
    always @* begin
        state_d    = state_q;
        launch     = 1'b0;
        launch_ch  = chan_q;
        launch_rep = 4'h0;
        round_go   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                launch    = 1'b1;
                launch_ch = single_on ? sel_chan : `ADCSEQ_CH_2V5;
                round_go  = !single_on;
            end
            ST_WAIT: begin
                if (slot_cnt_q == 23'h000001) begin
                    launch = 1'b1;
                    if (single_on) begin
                        launch_ch = sel_chan;
                    end else if (single_q) begin
                        // leaving single mode starts a fresh round
                        launch_ch = `ADCSEQ_CH_2V5;
                        round_go  = 1'b1;
                    end else if (!avg_off && rep_q != 4'hF) begin
                        launch_rep = rep_q + 4'h1;
                    end else if (chan_q != `ADCSEQ_CH_REMOTE2) begin
                        launch_ch = chan_q + 3'h1;
                    end else if (cycle_cnt_q <= 23'h000001) begin
                        // a sweep longer than the cycle period restarts at once
                        launch_ch = `ADCSEQ_CH_2V5;
                        round_go  = 1'b1;
                    end else begin
                        launch  = 1'b0;
                        state_d = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                if (single_on) begin
                    launch    = 1'b1;
                    launch_ch = sel_chan;
                end else if (cycle_cnt_q <= 23'h000001) begin
                    launch    = 1'b1;
                    launch_ch = `ADCSEQ_CH_2V5;
                    round_go  = 1'b1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (launch)
            state_d = ST_WAIT;
    end

    // sequencer registers; start to start is exactly one slot count, except across the gap at the end of a round
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q      <= ST_IDLE;
            chan_q       <= 3'h0;
            rep_q        <= 4'h0;
            slot_cnt_q   <= 23'h000000;
            cycle_cnt_q  <= 23'h000000;
            single_q     <= 1'b0;
            conv_start   <= 1'b0;
            conv_channel <= 3'h0;
            atten_bypass <= 1'b0;
            avg_start_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            conv_start  <= launch;
            avg_start_q <= launch && (launch_rep == 4'h0);
            if (cycle_cnt_q != 23'h000000)
                cycle_cnt_q <= cycle_cnt_q - 23'h000001;
            if (slot_cnt_q != 23'h000000)
                slot_cnt_q <= slot_cnt_q - 23'h000001;
            if (round_go)
                cycle_cnt_q <= long_cyc ? CYC_LONG[22:0] : CYC_CYCLE[22:0];
            if (launch) begin
                chan_q       <= launch_ch;
                rep_q        <= launch_rep;
                single_q     <= single_on;
                conv_channel <= launch_ch;
                atten_bypass <= bypass_for(launch_ch, bypass_all, bypass_cfg_q);
                slot_cnt_q   <= single_on ? CYC_VOLT[22:0] : slot_len(launch_ch);
            end
        end
    end

    // results tagged with the channel that produced them
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            result_valid   <= 1'b0;
            result_channel <= 3'h0;
            result_code    <= 10'h000;
        end else begin
            result_valid <= avg_vld;
            if (avg_vld) begin
                result_channel <= conv_channel;
                result_code    <= avg_code;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/adcseq_monitor.sv */
// bound checker for the conversion sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.vh"
module adcseq_monitor #(
    parameter CYC_VOLT   = 10,
    parameter CYC_REMOTE = 40,
    parameter CYC_LOCAL  = 20,
    parameter CYC_CYCLE  = 2000,
    parameter CYC_LONG   = 3000
) (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        conv_start,
    input wire logic [2:0]  conv_channel,
    input wire logic        atten_bypass,
    input wire logic        conv_done,
    input wire logic [11:0] conv_raw,
    input wire logic        result_valid,
    input wire logic [2:0]  result_channel,
    input wire logic [9:0]  result_code,
    input wire logic [7:0]  tach_min_high
);
    // settings must stand this long, past any slot and two rounds, before timing is judged
    localparam int QUIET = 7000;
    logic [7:0]  mode_q, cyc_q, byp_q, sel_q;
    logic [11:0] raw_q;
    logic [2:0]  prev_q;
    logic [15:0] idle_q, age_q, gap_q, rnd_q, slot;
    logic [4:0]  per;
    logic        quiet, single, byp_exp;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // register shadow and cycle counters; idle and age saturate
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {mode_q, cyc_q, byp_q} <= 24'h000000;
            sel_q <= `ADCSEQ_RST_TACH_CHSEL;
            {raw_q, prev_q} <= 15'h0000;
            {idle_q, age_q, gap_q, rnd_q} <= 64'h0;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `ADCSEQ_OFS_CYCLE_CFG:  cyc_q <= reg_wdata;
                    `ADCSEQ_OFS_TACH_CHSEL: sel_q <= reg_wdata;
                    `ADCSEQ_OFS_MODE_CFG:   mode_q <= reg_wdata;
                    `ADCSEQ_OFS_BYPASS_CFG: byp_q <= reg_wdata;
                    default: ;
                endcase
            end
            raw_q <= conv_raw;
            idle_q <= reg_wr ? 16'h0000 : idle_q + {15'h0000, ~&idle_q};
            age_q <= (conv_raw != raw_q) ? 16'h0000 : age_q + {15'h0000, ~&age_q};
            gap_q <= conv_start ? 16'h0001 : gap_q + 16'h0001;
            rnd_q <= (conv_start && conv_channel == 3'h0) ? 16'h0001 : rnd_q + 16'h0001;
            if (conv_start) prev_q <= conv_channel;
        end
    end
    // expected slot length of the previous channel and bypass of the current one
    assign quiet = idle_q > QUIET;
    assign single = mode_q[`ADCSEQ_BIT_SINGLE];
    assign per = {byp_q[7:6], 1'b0, byp_q[5:4]};
    assign byp_exp = conv_channel < 3'h5 && (mode_q[`ADCSEQ_BIT_BYPASS_ALL] || per[conv_channel]);
    assign slot = prev_q == `ADCSEQ_CH_LOCAL ? CYC_LOCAL : (prev_q[2] && prev_q[0]) ? CYC_REMOTE
                : CYC_VOLT;

    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too wide");
    chk_slot_time: assert property (conv_start && quiet && !single
        && !(conv_channel == 3'h0 && prev_q == 3'h7) |-> gap_q == slot) else $error("bad slot");
    chk_round_time: assert property (conv_start && conv_channel == 3'h0 && quiet
        && !single && mode_q[4] |-> rnd_q == (cyc_q[7] ? CYC_LONG : CYC_CYCLE))
        else $error("bad round length");
    chk_single_time: assert property (conv_start && quiet && single
        |-> gap_q == CYC_VOLT) else $error("bad single period");
    chk_single_chan: assert property (conv_start && quiet && single
        |-> conv_channel == sel_q[7:5]) else $error("bad single channel");
    chk_rr_order: assert property (conv_start && quiet && !single && mode_q[4]
        |-> conv_channel == prev_q + 3'h1) else $error("bad channel order");
    chk_bypass_sel: assert property (conv_start && quiet
        |-> atten_bypass == byp_exp) else $error("bad bypass level");
    // the tach copy is registered once more behind the selector byte
    chk_tach_copy: assert property (reg_wr && reg_addr == `ADCSEQ_OFS_TACH_CHSEL
        |-> ##2 tach_min_high == $past(reg_wdata, 2)) else $error("tach byte not copied");
    chk_result_chan: assert property (result_valid |-> result_channel == prev_q)
        else $error("bad result channel");
    chk_result_sat: assert property (result_valid && age_q > QUIET
        |-> result_code == ((conv_raw > 12'h3FF) ? 10'h3FF : conv_raw[9:0]))
        else $error("bad result code");
endmodule

bind adcseq_top adcseq_monitor #(.CYC_VOLT(CYC_VOLT), .CYC_REMOTE(CYC_REMOTE),
    .CYC_LOCAL(CYC_LOCAL), .CYC_CYCLE(CYC_CYCLE), .CYC_LONG(CYC_LONG)) adcseq_monitor_inst (
    .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_channel(conv_channel), .atten_bypass(atten_bypass),
    .conv_done(conv_done), .conv_raw(conv_raw), .result_valid(result_valid),
    .result_channel(result_channel), .result_code(result_code), .tach_min_high(tach_min_high));
`default_nettype wire

/* testbench/adcseq_top_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_defs.vh"
module adcseq_top_tb;
    logic        core_clk, reset, reg_wr, reg_rd, coll;
    logic        conv_done = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, mode, byp, d;
    logic [11:0] conv_raw;
    logic [2:0]  done_sh = 3'h0;
    logic [2:0]  chq[$];
    logic        bq[$];
    logic [7:0]  ofs[4] = '{8'h10, 8'h73, 8'h7D, 8'h55};
    int          num_errors, check_count, k;
    wire         conv_start, atten_bypass, result_valid;
    wire [7:0]   reg_rdata, tach_min_high;
    wire [2:0]   conv_channel, result_channel;
    wire [9:0]   result_code;

    adcseq_top #(.CYC_VOLT(10), .CYC_REMOTE(40), .CYC_LOCAL(20), .CYC_CYCLE(2000),
        .CYC_LONG(3000)) adcseq_top_inst (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_start(conv_start), .conv_channel(conv_channel), .atten_bypass(atten_bypass),
        .conv_done(conv_done), .conv_raw(conv_raw), .result_valid(result_valid),
        .result_channel(result_channel), .result_code(result_code), .tach_min_high(tach_min_high));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // analog side answers three cycles after each start
    always @(posedge core_clk) begin
        #1;
        conv_done = done_sh[2];
        done_sh = {done_sh[1:0], conv_start === 1'b1};
    end
    // record channel and bypass level of every start while collecting
    always @(posedge core_clk) begin
        if (coll && conv_start === 1'b1) begin
            chq.push_back(conv_channel);
            bq.push_back(atten_bypass);
        end
    end

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one register cycle; reads compare the answer of the next edge
    task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_rd = r;
        reg_wr = !r;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        if (r) check("reg_rdata", reg_rdata, v);
        @(posedge core_clk);
        #1;
    endtask
    // bounded wait for n starts
    task automatic collect(input int n);
        chq.delete();
        bq.delete();
        coll = 1'b1;
        for (int i = 0; i < 20000 && chq.size() < n; i++) @(posedge core_clk);
        coll = 1'b0;
        #1;
        if (chq.size() < n) begin
            check("start_count", 12'(chq.size()), 12'(n));
            complete_run();
        end
    endtask
    function automatic logic exp_byp(input logic [2:0] ch);
        logic [4:0] per;
        per = {byp[7:6], 1'b0, byp[5:4]};
        return ch < 3'h5 && (mode[5] || per[ch]);
    endfunction
    function automatic logic [9:0] exp_code(input logic [11:0] raw);
        return (raw > 12'h3FF) ? `ADCSEQ_CODE_MAX : raw[9:0];
    endfunction
    // bypass of each start, and channel stepping once every run starts
    task automatic scan(input int from, input int run);
        for (int i = from; i < chq.size(); i++) begin
            check("atten_bypass", bq[i], exp_byp(chq[i]));
            check("conv_channel", chq[i], 3'(chq[from] + (i - from) / run));
        end
    endtask
    // new settings, then long enough for them to govern whole rounds
    task automatic setup(input logic [7:0] c, input logic [7:0] m, input logic [11:0] raw);
        mode = m;
        byp = $urandom;
        conv_raw = raw;
        acc(1'b0, `ADCSEQ_OFS_CYCLE_CFG, c);
        acc(1'b0, `ADCSEQ_OFS_MODE_CFG, m);
        acc(1'b0, `ADCSEQ_OFS_BYPASS_CFG, byp);
        repeat (7000) @(posedge core_clk);
        #1;
    endtask
    task automatic complete_run();
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {reset, reg_wr, reg_rd, coll} = 4'b1000;
        {reg_addr, reg_wdata, conv_raw} = 28'h0;
        void'($urandom(50));
        repeat (12) @(posedge core_clk);
        #1;
        reset = 1'b0;
        // reset values, then an unmapped place that stays empty
        acc(1'b1, `ADCSEQ_OFS_CYCLE_CFG, `ADCSEQ_RST_CYCLE_CFG);
        acc(1'b1, `ADCSEQ_OFS_MODE_CFG, `ADCSEQ_RST_MODE_CFG);
        acc(1'b1, `ADCSEQ_OFS_BYPASS_CFG, `ADCSEQ_RST_BYPASS_CFG);
        acc(1'b1, `ADCSEQ_OFS_TACH_CHSEL, `ADCSEQ_RST_TACH_CHSEL);
        acc(1'b0, 8'h20, 8'hA5);
        acc(1'b1, 8'h20, 8'h00);
        foreach (ofs[i]) begin
            d = $urandom;
            acc(1'b0, ofs[i], d);
            acc(1'b1, ofs[i], d);
        end
        check("tach_min_high", tach_min_high, d);
        // averaging on: sixteen starts per channel
        setup(8'h00, 8'h00, $urandom);
        collect(64);
        k = 1;
        while (k < 17 && chq[k] === chq[0]) k++;
        scan(k, 16);
        check("result_code", result_code, exp_code(conv_raw));
        // averaging off, both round lengths, boundary raw codes
        for (int i = 0; i < 3; i++) begin
            setup({i[0], 7'h00}, 8'h10 | ($urandom & 8'h20),
                  i == 0 ? 12'h400 : i == 1 ? 12'h3FF : 12'($urandom));
            collect(16);
            scan(0, 1);
            check("result_code", result_code, exp_code(conv_raw));
        end
        // single mode on every selector code
        setup(8'h00, 8'h50, 12'h123);
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], 5'($urandom)};
            acc(1'b0, `ADCSEQ_OFS_TACH_CHSEL, d);
            check("tach_min_high", tach_min_high, d);
            repeat (100) @(posedge core_clk);
            collect(3);
            check("conv_channel", chq[0], i[2:0]);
            scan(0, 1000);
        end
        repeat (7100) @(posedge core_clk);
        #1;
        // leaving single mode brings the round robin back
        mode = 8'h10;
        acc(1'b0, `ADCSEQ_OFS_MODE_CFG, mode);
        repeat (300) @(posedge core_clk);
        collect(10);
        scan(0, 1);
        complete_run();
    end
endmodule
`default_nettype wire
